// ==== dv/ddr_sample_port_capture_test.sv ====
// bench: host end feeds device end across the link, samples checked at the far side
// assumes both user sides on sys_clk; the link clock comes from the host
`timescale 1ns/1ns
`default_nettype none
`include "dspc_map.svh"
module ddr_sample_port_capture_test;
    import dspc_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         byteMode = 1'b0;
    dspc_sample_t hData = 16'h0000;
    logic         hVal = 1'b0;
    logic         hRdy;
    logic [7:0]   ifConfig = 8'h00;
    logic [3:0]   phaseCtrl = 4'h0;
    dspc_sample_t dData;
    logic         dValid;
    logic         dReady = 1'b1;
    logic         aligned;
    logic [4:0]   samplePhase;
    logic         phaseInvalid;
    int           fails = 0;
    int           total_checks = 0;
    logic         watch = 1'b0;
    dspc_sample_t lastRaw = 16'h0000;
    dspc_sample_t lastExp = 16'h0000;
    dspc_sample_t expQ[$];
    dspc_sample_t pat[6] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h1234, 16'ha5c3};
    dspc_link_if link ();
    always #4 sys_clk = ~sys_clk;
    dspc_host_end u_dspc_host_end (.sys_clk(sys_clk), .rst_n(rst_n), .byteMode(byteMode),
        .sampleData(hData), .sampleValid(hVal), .sampleReady(hRdy), .link(link));
    dspc_device_end u_dspc_device_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .ifConfig(ifConfig), .phaseCtrl(phaseCtrl), .sampleData(dData), .sampleValid(dValid),
        .sampleReady(dReady), .aligned(aligned), .samplePhase(samplePhase), .phaseInvalid(phaseInvalid));
    dspc_link_sva u_dspc_link_sva (.sys_clk(sys_clk), .rst_n(rst_n), .byteMode(byteMode),
        .fwdClk(link.fwdClk), .frame(link.frame), .lanes(link.lanes));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // valid and data held until the edge that sees ready
    task automatic send(input dspc_sample_t s);
        hVal <= 1'b1;
        hData <= s;
        @(posedge sys_clk iff hRdy);
        lastRaw = s;
        expQ.push_back(ifConfig[`DSPC_CFG_FORMAT] ? {~s[15], s[14:0]} : s);
    endtask

    // the link never idles: between samples the last one is repeated
    task automatic configure(input logic [7:0] cfg, input logic bm);
        watch = 1'b0;
        ifConfig <= cfg;
        byteMode <= bm;
        repeat (16) @(posedge sys_clk);
        lastExp = cfg[`DSPC_CFG_FORMAT] ? {~lastRaw[15], lastRaw[14:0]} : lastRaw;
        watch = 1'b1;
    endtask

    task automatic drain();
        hVal <= 1'b0;
        for (int i = 0; i < 300 && expQ.size() != 0; i++) @(posedge sys_clk);
        check(16'(expQ.size()), 16'h0000);
        repeat (8) @(posedge sys_clk);
    endtask

    // negative settings pull the sampling point earlier than the nominal quarter period
    function automatic logic [15:0] phaseOf(input logic [3:0] p);
        return p[3] ? 16'(`DSPC_PHASE_NOMINAL - p[2:0]) : 16'(`DSPC_PHASE_NOMINAL + p[2:0]);
    endfunction

    always @(posedge sys_clk) begin
        if (rst_n && watch && dValid && dReady) begin
            if (expQ.size() != 0 && dData === expQ[0]) lastExp = expQ.pop_front();
            check(dData, lastExp);
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(16'(samplePhase), 16'h0008);
        check(16'({aligned, dValid}), 16'h0000);
        for (int p = 0; p < 16; p++) begin
            phaseCtrl <= 4'(p);
            repeat (8) @(posedge sys_clk);
            check(16'(phaseInvalid), 16'(p[2:0] == 3'h7));
            if (p[2:0] != 3'h7) check(16'(samplePhase), phaseOf(4'(p)));
        end
        for (int f = 0; f < 2; f++) begin
            configure(f ? 8'h80 : 8'h00, 1'b0);
            foreach (pat[i]) send(pat[i]);
            drain();
        end
        // a long stall keeps two repeated words; the stream resumes after it
        dReady <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check(16'(dValid), 16'h0001);
        dReady <= 1'b1;
        send(16'h0f0f);
        send(16'hf0f0);
        drain();
        for (int f = 0; f < 2; f++) begin
            configure(f ? 8'h81 : 8'h01, 1'b1);
            foreach (pat[i]) send(pat[i]);
            drain();
            check(16'(aligned), 16'h0001);
        end
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end
endmodule // ddr_sample_port_capture_test
`default_nettype wire

// ==== dv/dspc_link_sva.sv ====
// checker on the link wires between the host and capture ends
// assumes the host registers fwdClk, frame and lanes on sys_clk
`timescale 1ns/1ns
`default_nettype none
module dspc_link_sva (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        byteMode,
    input wire logic        fwdClk,
    input wire logic        frame,
    input wire logic [15:0] lanes
);
    logic [1:0] rises;
    // saturates so a burst of edges never wraps back to a legal count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rises <= 2'h0;
        else if (!byteMode)
            rises <= 2'h0;
        else if ($rose(frame) && rises != 2'h3)
            rises <= rises + 2'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_clk_rise: assert property (!fwdClk |=> fwdClk) else $error("link clock missed a rise");
    a_clk_fall: assert property (fwdClk |=> !fwdClk) else $error("link clock missed a fall");
    a_frame_width: assert property ($rose(frame) |=> frame) else $error("frame shorter than a period");
    a_frame_end: assert property ($rose(frame) |-> ##2 !frame) else $error("frame longer than a period");
    a_frame_gap: assert property ($fell(frame) |-> !frame [*2]) else $error("frame repeats too soon");
    a_frame_bytemode: assert property (frame |-> byteMode) else $error("frame outside byte mode");
    a_frame_once: assert property (rises <= 2'h1) else $error("frame sent twice");
    a_lanes_on_edge: assert property ($changed(lanes) |-> $changed(fwdClk)) else $error("lanes off clock");
endmodule // dspc_link_sva
`default_nettype wire

// ==== hw/dspc_device_end.sv ====
// device end: captures ddr lanes, rebuilds bytes, converts format
// assumes link clock from the host within the locking range; user side on sys_clk
// Notes on behaviour
// - word mode sixteen lanes, byte mode lower eight
// - bytes arrive upper first, then lower
// - host supplies frame aligned with data
// - frame rising edge marks first upper byte
// - alignment valid after first captured frame edge
// - single frame pulse lasts one clock period
// - repeating frame rate is clock over 2n; the host here sends one pulse only and the device ignores frames once aligned
// - config bit 7 selects binary or twos
// - host sends 16-bit data with ddr clock
// - sampling clock captures on both edges
// - forwarded clock between 250 and 575 MHz; here it is sys_clk/2 and no range is checked
// - clock edges coincide with data transitions; host here launches edges half a sys_clk after the lanes
// - zero offset lags clock by quarter period
// - phase offset is 4-bit sign magnitude
`timescale 1ns/1ns
`default_nettype none
`include "dspc_map.svh"
module dspc_device_end #(
    parameter int WIDTH = `DSPC_SAMPLE_W
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    dspc_link_if.device           link,
    input  wire logic [7:0]       ifConfig,
    input  wire logic [3:0]       phaseCtrl,
    output dspc_pkg::dspc_sample_t sampleData,
    output logic                  sampleValid,
    input  wire logic             sampleReady,
    output logic                  aligned,
    output logic [4:0]            samplePhase,
    output logic                  phaseInvalid
);
    import dspc_pkg::*;
    // ideal delay line modelled as a phase code in 11.25 degree steps of a period
    logic [4:0] next_phase;
    logic [2:0] mag;
    assign mag = phaseCtrl[2:0];
    always_comb begin
        if (phaseCtrl[`DSPC_PHASE_SIGN]) begin
            next_phase = 5'(`DSPC_PHASE_NOMINAL) - {2'b00, mag};
        end else begin
            next_phase = 5'(`DSPC_PHASE_NOMINAL) + {2'b00, mag};
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            samplePhase  <= 5'(`DSPC_PHASE_NOMINAL);
            phaseInvalid <= 1'b0;
        end else begin
            samplePhase  <= next_phase;
            phaseInvalid <= (mag == 3'(`DSPC_PHASE_MAG_MAX));
        end
    end
    // link domain: the host launches lanes half a sys_clk before each link edge,
    // so plain edge capture stands in for the quarter-period sampling lag
    logic [15:0] riseWord;
    logic [15:0] fallWord;
    logic        riseFrame;
    logic        fallFrame;
    always_ff @(posedge link.fwdClk or negedge rst_n) begin
        if (!rst_n) begin
            riseWord  <= '0;
            riseFrame <= 1'b0;
        end else begin
            riseWord  <= link.lanes;
            riseFrame <= link.frame;
        end
    end
    always_ff @(negedge link.fwdClk or negedge rst_n) begin
        if (!rst_n) begin
            fallWord  <= '0;
            fallFrame <= 1'b0;
        end else begin
            fallWord  <= link.lanes;
            fallFrame <= link.frame;
        end
    end
    // each rising edge pairs the previous rise slot with the fall slot after it
    logic        byteModeL1;
    logic        byteModeL2;
    logic        fmtL1;
    logic        fmtL2;
    logic        prevFrame;
    logic        lAligned;
    logic        lPush;
    logic        lToggle;
    logic [32:0] bank [2];
    always_ff @(posedge link.fwdClk or negedge rst_n) begin
        if (!rst_n) begin
            byteModeL1 <= 1'b0;
            byteModeL2 <= 1'b0;
            fmtL1      <= 1'b0;
            fmtL2      <= 1'b0;
        end else begin
            byteModeL1 <= ifConfig[`DSPC_CFG_BYTE_MODE];
            byteModeL2 <= byteModeL1;
            fmtL1      <= ifConfig[`DSPC_CFG_FORMAT];
            fmtL2      <= fmtL1;
        end
    end
    function automatic logic [15:0] fmt_conv(input logic [15:0] w, input logic offs);
        fmt_conv = offs ? {~w[15], w[14:0]} : w;
    endfunction
    // upper bytes must ride rise slots; a frame that starts on a fall slot is missed
    assign lPush = !byteModeL2 || lAligned || (riseFrame && !prevFrame);
    always_ff @(posedge link.fwdClk or negedge rst_n) begin
        if (!rst_n) begin
            prevFrame <= 1'b0;
            lAligned  <= 1'b0;
            lToggle   <= 1'b0;
        end else begin
            prevFrame <= fallFrame;
            lAligned  <= byteModeL2 && lPush;
            if (lPush) begin
                lToggle <= ~lToggle;
            end
        end
    end
    // two banks: the one read across the crossing is not rewritten for two link edges
    always_ff @(posedge link.fwdClk) begin
        if (!byteModeL2) begin
            bank[lToggle] <= {1'b1, fmt_conv(riseWord, fmtL2), fmt_conv(fallWord, fmtL2)};
        end else if (lPush) begin
            bank[lToggle] <= {1'b0, 16'h0000, fmt_conv({riseWord[7:0], fallWord[7:0]}, fmtL2)};
        end
    end
    // crossing: toggle event, the bank it names stays still until it is read
    logic        tgS1;
    logic        tgS2;
    logic        tgS3;
    logic        alS1;
    logic        alS2;
    logic [32:0] pend;
    logic [1:0]  pendCnt;
    logic [15:0] pushWord;
    logic        bufReady;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgS1 <= 1'b0;
            tgS2 <= 1'b0;
            tgS3 <= 1'b0;
            alS1 <= 1'b0;
            alS2 <= 1'b0;
            aligned <= 1'b0;
        end else begin
            tgS1 <= lToggle;
            tgS2 <= tgS1;
            tgS3 <= tgS2;
            alS1 <= lAligned;
            alS2 <= alS1;
            aligned <= alS2;
        end
    end
    // a word pair is pushed over two cycles, one word per cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend    <= '0;
            pendCnt <= 2'h0;
        end else if (tgS2 ^ tgS3) begin
            pend    <= bank[tgS3];
            pendCnt <= bank[tgS3][32] ? 2'h2 : 2'h1;
        end else if (pendCnt != 2'h0) begin
            pendCnt <= pendCnt - 2'h1;
        end
    end
    assign pushWord = (pendCnt == 2'h2) ? pend[31:16] : pend[15:0];
    // a stall past two words overruns; the link itself cannot be held off
    dspc_skid_buf #(.WIDTH(WIDTH), .DEPTH(2)) u_buf (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .inData  (pushWord),
        .inValid (pendCnt != 2'h0),
        .inReady (bufReady),
        .outData (sampleData),
        .outValid(sampleValid),
        .outReady(sampleReady)
    );
endmodule // dspc_device_end
`default_nettype wire

// ==== hw/dspc_host_end.sv ====
// host end: sends samples with a forwarded ddr clock and a frame
// assumes sys_clk domain for the user side; the link clock is divided from it
`timescale 1ns/1ns
`default_nettype none
`include "dspc_map.svh"
module dspc_host_end (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             byteMode,
    input  wire dspc_pkg::dspc_sample_t sampleData,
    input  wire logic             sampleValid,
    output logic                  sampleReady,
    dspc_link_if.host             link
);
    import dspc_pkg::*;
    // link clock is sys_clk/2; each sys_clk cycle carries one lane word
    logic         clkOut;
    logic         frameOut;
    logic [15:0]  lanesOut;
    dspc_sample_t held;
    logic         framed;
    logic         take;
    assign link.fwdClk = clkOut;
    assign link.frame  = frameOut;
    assign link.lanes  = lanesOut;
    // a word launched while clkOut is low is caught by a rising link edge
    assign take = sampleValid && sampleReady && (!byteMode || !clkOut);
    // edges launched half a sys_clk after the lanes: this stands in for the
    // sampling clock's quarter-period lag, as no delay element exists here
    // rate follows sys_clk; a real link needs it inside the locking range
    always_ff @(negedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkOut <= 1'b0;
        end else begin
            clkOut <= ~clkOut;
        end
    end
    // with no new sample the last one is sent again, so the stream never gaps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lanesOut    <= '0;
            held        <= '0;
            sampleReady <= 1'b0;
        end else begin
            sampleReady <= byteMode ? clkOut : 1'b1;
            if (take) begin
                held <= sampleData;
            end
            if (!byteMode) begin
                lanesOut <= take ? sampleData : held;
            end else if (!clkOut) begin
                lanesOut <= {8'h00, take ? sampleData[15:8] : held[15:8]};
            end else begin
                lanesOut <= {8'h00, held[7:0]};
            end
        end
    end
    // one frame pulse over an upper and a lower byte: one whole link period
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frameOut <= 1'b0;
            framed   <= 1'b0;
        end else begin
            frameOut <= (byteMode && take && !framed) || (frameOut && clkOut);
            if (!byteMode) begin
                framed <= 1'b0;
            end else if (take) begin
                framed <= 1'b1;
            end
        end
    end
endmodule // dspc_host_end
`default_nettype wire

// ==== hw/dspc_skid_buf.sv ====
// two-entry buffer with valid and ready on both sides
// assumes one clock domain for both sides
`timescale 1ns/1ns
`default_nettype none
module dspc_skid_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrIdx;
    logic [AW-1:0]    rdIdx;
    logic [AW:0]      count;
    logic             doWr;
    logic             doRd;
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = store[rdIdx];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    always_ff @(posedge clk) begin
        if (doWr) begin
            store[wrIdx] <= inData;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrIdx <= '0;
            rdIdx <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrIdx <= (wrIdx == AW'(DEPTH-1)) ? '0 : wrIdx + 1'b1;
            end
            if (doRd) begin
                rdIdx <= (rdIdx == AW'(DEPTH-1)) ? '0 : rdIdx + 1'b1;
            end
            count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule // dspc_skid_buf
`default_nettype wire

// ==== shared/dspc_link_if.sv ====
// link between host and capture ends: forwarded clock, frame and data lanes
// assumes the host drives every signal; the device only samples
`timescale 1ns/1ns
`default_nettype none
interface dspc_link_if;
    logic        fwdClk;
    logic        frame;
    logic [15:0] lanes;
    modport host (output fwdClk, output frame, output lanes);
    modport device (input fwdClk, input frame, input lanes);
endinterface
`default_nettype wire

// ==== shared/dspc_map.svh ====
// constants for the ddr sample port capture block
// assumes inclusion by bare name from design and bench files
`ifndef DSPC_MAP_SVH
`define DSPC_MAP_SVH
`define DSPC_SAMPLE_W        16
`define DSPC_BYTE_W          8
`define DSPC_CFG_BYTE_MODE   0
`define DSPC_CFG_FORMAT      7
`define DSPC_PHASE_W         4
`define DSPC_PHASE_SIGN      3
`define DSPC_PHASE_MAG_MAX   7
`define DSPC_PHASE_STEPS     32
`define DSPC_PHASE_NOMINAL   8
`define DSPC_DLL_MIN_MHZ     250
`define DSPC_DLL_MAX_MHZ     575
`define DSPC_LINK_DIV        2
`define DSPC_FRAME_PERIODS   1
`endif

// ==== shared/dspc_pkg.sv ====
// types shared by both ends of the sample port
// assumes dspc_map.svh on the include path
`include "dspc_map.svh"
package dspc_pkg;
    typedef logic [`DSPC_SAMPLE_W-1:0] dspc_sample_t;
    typedef logic [`DSPC_BYTE_W-1:0]   dspc_byte_t;
    typedef enum logic {DSPC_FMT_TWOS, DSPC_FMT_OFFSET} dspc_fmt_t;
endpackage
